// file: dsk_sequencer.sv
// Dual slope touch key sequencer with APB register set
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// [R1] Normal mode: start write runs one sequence
// [R2] Auto mode: count above threshold raises irq, wakeup
// [R3] Writing auto bit one launches auto conversion
// [R4] Start bit cleared by hardware completion or by clearing enable
// [R5] Busy reads one while sequence runs
// [R6] Cycle field selects exact per sequence count
// [R7] Repeat field reruns and accumulates sequences
// [R8] Baseline is moving average, window 32..256
// [R9] Seed select: first count or written baseline
// [R10] Threshold alone or threshold plus baseline
// [R11] Optional selectable delay before auto sequence
// [R12] Long noise ignored by duty counters only
// [R13] Auto filter enable; noise flag always reported
// [R14] Reference capacitor select, three bit field
// [R15] Random enable randomizes conversion timing
// [R16] Software should pick slow clock for low power
// [R17] Duty counts readable as bytes, writes ignored
// [R18] DC pull: current, resistor, four bit select
// [R19] Charge periods high count, discharge low count
// [R20] Accumulate up to sixteen conversions
// [R21] Irq flag sticky until cleared, gated by enable
// [R22] Noise flag sticky until software writes zero or enable is cleared
module dsk_sequencer
	import dsk_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic duty_level,
	input wire logic noise_detect,
	input wire logic slow_osc,
	output dsk_analog_type analog,
	output logic irq,
	output logic wakeup
);
	logic [7:0] cfg_a, cfg_b, cfg_c, cfg_d, pull;
	logic [15:0] thr, base, hduty, lduty;
	dsk_state_type state;
	logic duty_s1, duty_s2, noise_s1, noise_s2, slow_s1, slow_s2, slow_d;
	logic [7:0] div_cnt;
	logic conv_clk, tick;
	logic [7:0] lfsr;
	logic [15:0] wait_cnt;
	logic [16:0] cyc_cnt;
	logic [4:0] rep_cnt;
	logic [20:0] acc_hi, acc_lo;
	logic [5:0] noise_run;
	logic auto_pending, first_auto;
	logic [15:0] idx;
	logic sel_ok, wr_en, rd_setup, wr_d;
	logic [7:0] rd_byte;
	logic [15:0] res_hi, res_lo;
	logic [16:0] thr_eff;
	logic finish, detect, noise_hit, filter_on;
	logic [5:0] noise_limit;

	function automatic logic [16:0] cycle_total(input logic [2:0] code);
		case (code)
			3'd0: cycle_total = 17'h0_0400;
			3'd1: cycle_total = 17'h0_0800;
			3'd2: cycle_total = 17'h0_1000;
			3'd3: cycle_total = 17'h0_2000;
			3'd4: cycle_total = 17'h0_3000;
			3'd5: cycle_total = 17'h0_4000;
			3'd6: cycle_total = 17'h0_8000;
			default: cycle_total = 17'h1_0000;
		endcase
	endfunction : cycle_total

	function automatic logic [4:0] rep_total(input logic [1:0] code);
		case (code)
			2'd0: rep_total = 5'd1;
			2'd1: rep_total = 5'd4;
			2'd2: rep_total = 5'd8;
			default: rep_total = 5'd16;
		endcase
	endfunction : rep_total

	function automatic logic [2:0] rep_shift(input logic [1:0] code);
		case (code)
			2'd0: rep_shift = 3'd0;
			2'd1: rep_shift = 3'd2;
			2'd2: rep_shift = 3'd3;
			default: rep_shift = 3'd4;
		endcase
	endfunction : rep_shift

	function automatic logic [7:0] div_half(input logic [2:0] code);
		case (code)
			3'd0: div_half = 8'd1;
			3'd1: div_half = 8'd2;
			3'd2: div_half = 8'd3;
			3'd3: div_half = 8'd4;
			3'd4: div_half = 8'd5;
			3'd5: div_half = 8'd8;
			default: div_half = 8'd16;
		endcase
	endfunction : div_half

	function automatic logic [15:0] sat16(input logic [20:0] v);
		sat16 = (v[20:16] != 5'd0) ? 16'hffff : v[15:0];
	endfunction : sat16

	// Synchronisers for pins from the analog side
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			duty_s1 <= 1'b0;
			duty_s2 <= 1'b0;
			noise_s1 <= 1'b0;
			noise_s2 <= 1'b0;
			slow_s1 <= 1'b0;
			slow_s2 <= 1'b0;
			slow_d <= 1'b0;
		end else begin
			duty_s1 <= duty_level;
			duty_s2 <= duty_s1;
			noise_s1 <= noise_detect;
			noise_s2 <= noise_s1;
			slow_s1 <= slow_osc;
			slow_s2 <= slow_s1;
			slow_d <= slow_s2;
		end
	end

	// Converter clock divider with optional random stretch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= 8'd0;
			conv_clk <= 1'b0;
			tick <= 1'b0;
			lfsr <= LFSR_SEED;
		end else begin
			tick <= 1'b0;
			if (cfg_a[A_CS_LSB +: 3] == 3'd7) begin
				if (slow_s2 && !slow_d) begin
					conv_clk <= !conv_clk;
					tick <= !conv_clk;
				end
			end else if (div_cnt + 8'd1 >= div_half(cfg_a[A_CS_LSB +: 3])) begin
				div_cnt <= 8'd0;
				if (!(cfg_d[D_RND] && lfsr[0] && conv_clk)) begin // [R15]
					conv_clk <= !conv_clk;
					tick <= !conv_clk;
				end
			end else begin
				div_cnt <= div_cnt + 8'd1;
			end
			if (tick) begin
				lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]}; // [R15]
			end
		end
	end

	// APB decode
	assign idx = paddr[ADDR_W-1:2];
	assign sel_ok = (paddr[1:0] == 2'b00) && (idx == IDX_CFG_A || idx == IDX_CFG_B
		|| idx == IDX_CFG_C || idx == IDX_CFG_D || idx == IDX_HDUTY_L
		|| idx == IDX_HDUTY_H || idx == IDX_LDUTY_L || idx == IDX_LDUTY_H
		|| idx == IDX_BASE_L || idx == IDX_BASE_H || idx == IDX_THR_L
		|| idx == IDX_THR_H || idx == IDX_PULL);
	assign rd_setup = psel && !penable;
	assign wr_en = psel && penable && pready && pwrite && sel_ok && pstrb[0];
	assign wr_d = wr_en && idx == IDX_CFG_D;

	always_comb begin
		case (idx)
			IDX_CFG_A: rd_byte = cfg_a;
			IDX_CFG_B: rd_byte = cfg_b;
			IDX_CFG_C: rd_byte = cfg_c;
			IDX_CFG_D: rd_byte = {cfg_d[7:1],
				state != ST_IDLE || cfg_d[D_START] || auto_pending}; // [R5]
			IDX_HDUTY_L: rd_byte = hduty[7:0]; // [R17]
			IDX_HDUTY_H: rd_byte = hduty[15:8]; // [R17]
			IDX_LDUTY_L: rd_byte = lduty[7:0]; // [R17]
			IDX_LDUTY_H: rd_byte = lduty[15:8]; // [R17]
			IDX_BASE_L: rd_byte = base[7:0];
			IDX_BASE_H: rd_byte = base[15:8];
			IDX_THR_L: rd_byte = thr[7:0];
			IDX_THR_H: rd_byte = thr[15:8];
			IDX_PULL: rd_byte = {pull[7:6], 2'b00, pull[3:0]};
			default: rd_byte = 8'h00;
		endcase
	end

	// APB answer: no wait state, registered data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= rd_setup;
			pslverr <= rd_setup && !sel_ok;
			if (rd_setup) begin
				prdata <= (sel_ok && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
			end
		end
	end

	// Plain configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_a <= RST_BYTE;
			cfg_b <= RST_BYTE;
			cfg_c <= RST_BYTE;
			pull <= RST_BYTE;
			thr <= {RST_BYTE, RST_BYTE};
		end else if (wr_en) begin
			case (idx)
				IDX_CFG_A: cfg_a <= pwdata[7:0];
				IDX_CFG_B: cfg_b <= pwdata[7:0];
				IDX_CFG_C: cfg_c <= pwdata[7:0];
				IDX_PULL: pull <= {pwdata[7:6], 2'b00, pwdata[3:0]}; // [R18]
				IDX_THR_L: thr[7:0] <= pwdata[7:0];
				IDX_THR_H: thr[15:8] <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// Sequence results and comparison
	assign finish = state == ST_FINISH;
	assign res_hi = sat16(acc_hi >> rep_shift(cfg_b[B_RPT_LSB +: 2])); // [R20]
	assign res_lo = sat16(acc_lo >> rep_shift(cfg_b[B_RPT_LSB +: 2])); // [R20]
	assign thr_eff = cfg_c[C_THRESHOLD_MODE_SELECT] ? {1'b0, thr} + {1'b0, base} : {1'b0, thr}; // [R10]
	assign detect = cfg_a[A_AUTO] && ({1'b0, res_lo} > thr_eff); // [R2]
	assign noise_limit = (cfg_b[B_LFN_LSB +: 2] == 2'd0) ? NOISE_UNIT
		: 6'(cfg_b[B_LFN_LSB +: 2] * NOISE_UNIT); // [R12]
	assign noise_hit = noise_s2 && (noise_run >= noise_limit);
	assign filter_on = (cfg_b[B_LFN_LSB +: 2] != 2'd0)
		&& (!cfg_a[A_AUTO] || cfg_c[C_AUTOLF]); // [R13]

	// Sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			wait_cnt <= 16'd0;
			cyc_cnt <= 17'd0;
			rep_cnt <= 5'd0;
			acc_hi <= 21'd0;
			acc_lo <= 21'd0;
			noise_run <= 6'd0;
		end else if (!cfg_a[A_EN]) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if ((cfg_d[D_START] && !cfg_a[A_AUTO]) || auto_pending) begin // [R1] [R3]
						if (cfg_a[A_AUTO] && cfg_d[D_DLYEN]) begin // [R11]
							state <= ST_DELAY;
							wait_cnt <= 16'({14'd0, cfg_b[B_DLY_LSB +: 2]} + 16'd1) * DELAY_UNIT;
						end else begin
							state <= ST_SETTLE;
							wait_cnt <= 16'({14'd0, cfg_b[B_INI_LSB +: 2]} + 16'd1) * SETTLE_UNIT;
						end
					end
				end
				ST_DELAY: begin
					if (tick) begin
						if (wait_cnt <= 16'd1) begin
							state <= ST_SETTLE;
							wait_cnt <= 16'({14'd0, cfg_b[B_INI_LSB +: 2]} + 16'd1) * SETTLE_UNIT;
						end else begin
							wait_cnt <= wait_cnt - 16'd1;
						end
					end
				end
				ST_SETTLE: begin
					cyc_cnt <= 17'd0;
					rep_cnt <= 5'd0;
					acc_hi <= 21'd0;
					acc_lo <= 21'd0;
					noise_run <= 6'd0;
					if (tick) begin
						if (wait_cnt <= 16'd1) begin
							state <= ST_RUN;
						end else begin
							wait_cnt <= wait_cnt - 16'd1;
						end
					end
				end
				ST_RUN: begin
					if (tick) begin
						noise_run <= noise_s2 ? ((noise_run == 6'h3f) ? noise_run
							: noise_run + 6'd1) : 6'd0;
						if (!(filter_on && noise_hit)) begin // [R12]
							if (duty_s2) begin
								acc_hi <= acc_hi + 21'd1; // [R19]
							end else begin
								acc_lo <= acc_lo + 21'd1; // [R19]
							end
						end
						if (cyc_cnt + 17'd1 >= cycle_total(cfg_c[C_CYC_LSB +: 3])) begin // [R6]
							cyc_cnt <= 17'd0;
							if (rep_cnt + 5'd1 >= rep_total(cfg_b[B_RPT_LSB +: 2])) begin // [R7]
								state <= ST_FINISH;
							end else begin
								rep_cnt <= rep_cnt + 5'd1;
							end
						end else begin
							cyc_cnt <= cyc_cnt + 17'd1;
						end
					end
				end
				ST_FINISH: begin
					if (cfg_a[A_AUTO]) begin
						if (cfg_d[D_DLYEN]) begin // [R11]
							state <= ST_DELAY;
							wait_cnt <= 16'({14'd0, cfg_b[B_DLY_LSB +: 2]} + 16'd1) * DELAY_UNIT;
						end else begin
							state <= ST_SETTLE;
							wait_cnt <= 16'({14'd0, cfg_b[B_INI_LSB +: 2]} + 16'd1) * SETTLE_UNIT;
						end
					end else begin
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Auto launch request and first conversion marker
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			auto_pending <= 1'b0;
			first_auto <= 1'b0;
		end else begin
			if (wr_en && idx == IDX_CFG_A && pwdata[A_AUTO] && pwdata[A_EN]) begin
				auto_pending <= 1'b1; // [R3]
				first_auto <= 1'b1;
			end else if (state != ST_IDLE || !cfg_a[A_AUTO]) begin
				auto_pending <= 1'b0;
			end
			if (finish) begin
				first_auto <= 1'b0;
			end
		end
	end

	// Result registers and baseline average
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hduty <= {RST_BYTE, RST_BYTE};
			lduty <= {RST_BYTE, RST_BYTE};
			base <= {RST_BYTE, RST_BYTE};
		end else if (finish) begin
			hduty <= res_hi; // [R19]
			lduty <= res_lo; // [R19]
			if (cfg_a[A_AUTO]) begin
				if (first_auto && cfg_c[C_SEED]) begin
					base <= res_lo; // [R9]
				end else begin
					base <= 16'($signed({2'b00, base})
						+ (($signed({2'b00, res_lo}) - $signed({2'b00, base}))
						>>> (5 + cfg_c[C_SLOW_LSB +: 2]))); // [R8] [R9]
				end
			end
		end else if (wr_en && idx == IDX_BASE_L) begin
			base[7:0] <= pwdata[7:0];
		end else if (wr_en && idx == IDX_BASE_H) begin
			base[15:8] <= pwdata[7:0];
		end
	end

	// Status and start register; hardware set of a flag wins over software clear, hardware clear of start wins over software set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_d <= RST_BYTE;
		end else if (!cfg_a[A_EN]) begin
			cfg_d[D_START] <= 1'b0;
			cfg_d[D_IRQF] <= 1'b0;
			cfg_d[D_LOW_FREQ_NOISE_SETTING_FLAG] <= 1'b0;
			if (wr_d) begin
				cfg_d[7:3] <= pwdata[7:3];
			end
		end else begin
			if (wr_d) begin
				cfg_d[7:3] <= pwdata[7:3]; // [R14] [R15] [R11]
			end
			if (finish) begin
				cfg_d[D_START] <= 1'b0; // [R4]
			end else if (wr_d && pwdata[D_START]) begin
				cfg_d[D_START] <= 1'b1; // [R1]
			end
			if ((finish && !cfg_a[A_AUTO]) || (finish && detect)) begin
				cfg_d[D_IRQF] <= 1'b1; // [R21] [R1] [R2]
			end else if (wr_d && !pwdata[D_IRQF]) begin
				cfg_d[D_IRQF] <= 1'b0; // [R21]
			end
			if (state == ST_RUN && tick && noise_hit) begin
				cfg_d[D_LOW_FREQ_NOISE_SETTING_FLAG] <= 1'b1; // [R22] [R13]
			end else if (wr_d && !pwdata[D_LOW_FREQ_NOISE_SETTING_FLAG]) begin
				cfg_d[D_LOW_FREQ_NOISE_SETTING_FLAG] <= 1'b0; // [R22]
			end
		end
	end

	// Outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
			wakeup <= 1'b0;
			analog <= '0;
		end else begin
			irq <= cfg_d[D_IRQF] && cfg_a[A_IRQEN]; // [R21]
			wakeup <= finish && detect; // [R2]
			analog.converter_clock <= conv_clk;
			analog.conv_active <= state == ST_RUN;
			analog.random_step <= cfg_d[D_RND] && lfsr[1]; // [R15]
			analog.guard_buffer_enable <= cfg_a[A_GUARD];
			analog.ultra_low_power_select <= cfg_a[A_LPM]; // [R16]
			analog.reference_cap_select <= cfg_d[D_CAP_LSB +: 3]; // [R14]
			analog.dc_current_enable <= pull[P_CUR]; // [R18]
			analog.dc_resistor_enable <= pull[P_RES]; // [R18]
			analog.dc_pull_select <= pull[P_SEL_LSB +: 4]; // [R18]
		end
	end
endmodule : dsk_sequencer
`default_nettype wire

// file: dsk_pkg.sv
// Shared constants, types and register map of the dual slope touch key sequencer
package dsk_pkg;
	localparam int ADDR_W = 18;
	// Register indexes; byte address is four times the index
	localparam logic [15:0] IDX_CFG_A = 16'ha018;
	localparam logic [15:0] IDX_CFG_B = 16'ha019;
	localparam logic [15:0] IDX_CFG_C = 16'ha01a;
	localparam logic [15:0] IDX_CFG_D = 16'ha01b;
	localparam logic [15:0] IDX_HDUTY_L = 16'ha01c;
	localparam logic [15:0] IDX_HDUTY_H = 16'ha01d;
	localparam logic [15:0] IDX_LDUTY_L = 16'ha01e;
	localparam logic [15:0] IDX_LDUTY_H = 16'ha01f;
	localparam logic [15:0] IDX_BASE_L = 16'ha028;
	localparam logic [15:0] IDX_BASE_H = 16'ha029;
	localparam logic [15:0] IDX_THR_L = 16'ha02a;
	localparam logic [15:0] IDX_THR_H = 16'ha02b;
	localparam logic [15:0] IDX_PULL = 16'ha02c;
	localparam logic [7:0] RST_BYTE = 8'h00;
	// Configuration A fields
	localparam int A_EN = 7;
	localparam int A_CS_LSB = 4;
	localparam int A_GUARD = 3;
	localparam int A_IRQEN = 2;
	localparam int A_LPM = 1;
	localparam int A_AUTO = 0;
	// Configuration B fields
	localparam int B_RPT_LSB = 6;
	localparam int B_INI_LSB = 4;
	localparam int B_DLY_LSB = 2;
	localparam int B_LFN_LSB = 0;
	// Configuration C fields
	localparam int C_SLOW_LSB = 6;
	localparam int C_CYC_LSB = 3;
	localparam int C_SEED = 2;
	localparam int C_THRESHOLD_MODE_SELECT = 1;
	localparam int C_AUTOLF = 0;
	// Configuration and status D fields
	localparam int D_CAP_LSB = 5;
	localparam int D_DLYEN = 4;
	localparam int D_RND = 3;
	localparam int D_LOW_FREQ_NOISE_SETTING_FLAG = 2;
	localparam int D_IRQF = 1;
	localparam int D_START = 0;
	// DC pull fields
	localparam int P_CUR = 7;
	localparam int P_RES = 6;
	localparam int P_SEL_LSB = 0;
	// Converter clock cycles per unit of settle and start delay
	localparam logic [15:0] SETTLE_UNIT = 16'h0010;
	localparam logic [15:0] DELAY_UNIT = 16'h0100;
	localparam logic [5:0] NOISE_UNIT = 6'h08;
	localparam logic [7:0] LFSR_SEED = 8'h01;

	typedef enum logic [2:0] {
		ST_IDLE, ST_DELAY, ST_SETTLE, ST_RUN, ST_FINISH
	} dsk_state_type;

	typedef struct packed {
		logic converter_clock;
		logic conv_active;
		logic random_step;
		logic guard_buffer_enable;
		logic ultra_low_power_select;
		logic [2:0] reference_cap_select;
		logic dc_current_enable;
		logic dc_resistor_enable;
		logic [3:0] dc_pull_select;
	} dsk_analog_type;
endpackage : dsk_pkg

// file: dsk_sequencer_sva.sv
// Port level assertions for the touch key sequencer
`timescale 1ns/100ps
`default_nettype none
module dsk_sequencer_sva
	import dsk_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire dsk_analog_type analog,
	input wire logic irq,
	input wire logic wakeup
);
	logic wr;
	logic wrote;
	logic [7:0] last_wd;
	logic [31:0] run_len;
	assign wr = psel && penable && pready && pwrite && pstrb[0];
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Length of the present run and whether software touched it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_len <= '0;
			wrote <= 1'b0;
			last_wd <= '0;
		end else begin
			run_len <= analog.conv_active ? run_len + 32'd1 : '0;
			wrote <= analog.conv_active && (wrote || wr);
			last_wd <= wr ? pwdata[7:0] : last_wd;
		end
	end
	irq_fall_a: assert property ($fell(irq) |-> $past(wr, 1) || $past(wr, 2) || $past(wr, 3))
		else $error("irq fell without a write");
	wake_pulse_a: assert property (wakeup |=> !wakeup)
		else $error("wakeup longer than one cycle");
	pull_sel_a: assert property (wr && paddr == {IDX_PULL, 2'b00} |=> ##1
		analog.dc_pull_select == last_wd[3:0])
		else $error("pull select not applied");
	pull_en_a: assert property (wr && paddr == {IDX_PULL, 2'b00} |-> ##2
		{analog.dc_current_enable, analog.dc_resistor_enable} == last_wd[7:6])
		else $error("pull enables not applied");
	cap_sel_a: assert property (wr && paddr == {IDX_CFG_D, 2'b00} |-> ##2
		analog.reference_cap_select == last_wd[7:5])
		else $error("reference capacitor not applied");
	conv_len_a: assert property ($fell(analog.conv_active) && !wrote |-> run_len >= 32'd2000)
		else $error("conversion shorter than the cycle count");
	busy_rd_a: assert property (pready && !pwrite && paddr == {IDX_CFG_D, 2'b00}
		&& analog.conv_active && $past(analog.conv_active) |-> prdata[0])
		else $error("busy low while converting");
	duty_rd_a: assert property (pready && !pwrite
		&& paddr[17:2] inside {[IDX_HDUTY_L:IDX_LDUTY_H]} |-> !pslverr && prdata[31:8] == 24'h0)
		else $error("duty read malformed");
endmodule : dsk_sequencer_sva
`default_nettype wire

// file: dsk_key_model.sv
// Behavioural touch key and integration capacitor
`timescale 1ns/100ps
`default_nettype none
module dsk_key_model
	import dsk_pkg::*;
(
	input wire logic pclk,
	input wire dsk_analog_type analog,
	input wire logic noise_on,
	output logic duty_level,
	output logic noise_detect,
	output logic slow_osc
);
	logic [1:0] phase = 2'b00;
	logic level = 1'b0;
	logic noise = 1'b0;
	logic osc = 1'b0;
	assign duty_level = level;
	assign noise_detect = noise;
	assign slow_osc = osc;
	// Slow oscillator runs free
	always #40 osc = ~osc;
	// Key charges one converter tick in four
	always @(posedge analog.converter_clock) phase <= phase + 2'b01;
	// Comparator output wanders while idle
	always @(posedge pclk) begin
		level <= analog.conv_active ? (phase == 2'b00) : ~level;
		noise <= noise_on;
	end
endmodule : dsk_key_model
`default_nettype wire

// file: dsk_sequencer_test.sv
// Testbench for the touch key sequencer
`timescale 1ns/100ps
`default_nettype none
bind dsk_sequencer dsk_sequencer_sva chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pstrb, .prdata, .pready, .pslverr, .analog, .irq, .wakeup);
module dsk_sequencer_test
	import dsk_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic duty_level;
	logic noise_detect;
	logic slow_osc;
	logic noise_on = 1'b0;
	dsk_analog_type analog;
	logic irq;
	logic wakeup;
	logic [33:0] notes[$];
	int n_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	integer seed = 35980;
	logic [7:0] d;
	logic [7:0] v;
	logic [16:0] sum;
	always #4 pclk = ~pclk;
	dsk_sequencer uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb(4'hf), .prdata, .pready, .pslverr, .duty_level, .noise_detect, .slow_osc,
		.analog, .irq, .wakeup);
	dsk_key_model key (.pclk, .analog, .noise_on, .duty_level, .noise_detect, .slow_osc);
	task automatic check(input logic [32:0] got, input logic [32:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic end_of_test;
		$display("comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_of_test
	task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		d = prdata[7:0];
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [15:0] idx, input logic [8:0] exp, input logic chk);
		notes.push_back({chk, exp[8], 24'h0, exp[7:0]});
		apb(1'b0, idx, 8'h00);
	endtask : rd
	task automatic conv(input logic [7:0] b, input logic [7:0] start);
		apb(1'b1, IDX_CFG_B, b);
		apb(1'b1, IDX_CFG_D, start);
		d = 8'h01;
		while (d[0] !== 1'b0) rd(IDX_CFG_D, 9'h000, 1'b0);
		sum = '0;
		for (int i = 0; i < 4; i++) begin
			rd(IDX_HDUTY_L + 16'(i), 9'h000, 1'b0);
			sum = sum + (i[0] ? {1'b0, d, 8'h00} : {9'h000, d});
		end
	endtask : conv
	// Read results are compared in arrival order
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
			if (notes[0][33]) check({pslverr, prdata}, notes[0][32:0]);
			void'(notes.pop_front());
		end
	end
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 40000) begin
			n_errors++;
			end_of_test();
		end
	end
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 13; i++) rd(IDX_CFG_A + 16'(i < 8 ? i : i + 8), 9'h000, 1'b1);
		rd(16'ha020, 9'h100, 1'b1);
		apb(1'b1, IDX_LDUTY_L, 8'h5a);
		rd(IDX_LDUTY_L, 9'h000, 1'b1);
		for (int i = 0; i < 5; i++) begin
			v = 8'($random(seed));
			apb(1'b1, IDX_BASE_L + 16'(i), v);
			rd(IDX_BASE_L + 16'(i), {1'b0, i == 4 ? v & 8'hcf : v}, 1'b1);
		end
		apb(1'b1, IDX_CFG_C, 8'h00);
		apb(1'b1, IDX_CFG_A, 8'h84);
		conv(8'h00, 8'he1);
		check({16'h0, sum}, 33'h400);
		rd(IDX_CFG_D, 9'h0e2, 1'b1);
		check({32'h0, irq}, 33'h1);
		conv(8'h40, 8'h01);
		check({32'h0, sum inside {17'h3ff, 17'h400}}, 33'h1);
		noise_on <= 1'b1;
		conv(8'h01, 8'h01);
		check({32'h0, sum < 17'h400}, 33'h1);
		rd(IDX_CFG_D, 9'h006, 1'b1);
		noise_on <= 1'b0;
		apb(1'b1, IDX_CFG_D, 8'h00);
		rd(IDX_CFG_D, 9'h000, 1'b1);
		check({32'h0, irq}, 33'h0);
		apb(1'b1, IDX_THR_L, 8'h00);
		apb(1'b1, IDX_THR_H, 8'h01);
		apb(1'b1, IDX_CFG_B, 8'h00);
		apb(1'b1, IDX_CFG_A, 8'h85);
		for (int i = 0; i < 6000 && wakeup !== 1'b1; i++) @(posedge pclk);
		check({32'h0, wakeup}, 33'h1);
		repeat (2) @(posedge pclk);
		check({32'h0, irq}, 33'h1);
		apb(1'b1, IDX_CFG_A, 8'h00);
		end_of_test();
	end
endmodule : dsk_sequencer_test
`default_nettype wire
